// ==== logic/ssp_pkg.sv ====
// shared constants and types of the synchronous serial port
package ssp_pkg;
  // port control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 5;
  localparam int unsigned CTRL_POLARITY_BIT = 4;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_MODE_W = 4;
  // peripheral flag register field
  localparam int unsigned FLAG_DONE_BIT = 3;
  // direction register fields, 1 = input
  localparam int unsigned DIR_SDI_BIT = 4;
  localparam int unsigned DIR_SDO_BIT = 5;
  localparam int unsigned DIR_SCK_BIT = 3;
  localparam int unsigned DIR_SS_BIT = 5;
  // pin vector positions
  localparam int unsigned PIN_SCK = 0;
  localparam int unsigned PIN_SDI = 1;
  localparam int unsigned PIN_SDO = 2;
  localparam int unsigned PIN_SS = 3;
  localparam int unsigned PIN_COUNT = 4;
  // mode select encodings
  localparam logic [3:0] MODE_M_DIV4 = 4'h0;
  localparam logic [3:0] MODE_M_DIV16 = 4'h1;
  localparam logic [3:0] MODE_M_DIV64 = 4'h2;
  localparam logic [3:0] MODE_M_TIMER = 4'h3;
  localparam logic [3:0] MODE_S_SELECT = 4'h4;
  localparam logic [3:0] MODE_S_NOSELECT = 4'h5;
  // bit clock ratios against the core clock, half period counter tops, one cycle below the half period
  localparam int unsigned RATIO_DIV4 = 4;
  localparam int unsigned RATIO_DIV16 = 16;
  localparam int unsigned RATIO_DIV64 = 64;
  localparam logic [4:0] HALF_TOP_DIV4 = 5'(RATIO_DIV4 / 2 - 1);
  localparam logic [4:0] HALF_TOP_DIV16 = 5'(RATIO_DIV16 / 2 - 1);
  localparam logic [4:0] HALF_TOP_DIV64 = 5'(RATIO_DIV64 / 2 - 1);
  // byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int unsigned TX_FIFO_DEPTH = 8;
  localparam int unsigned DATA_W = 8;
  // master sequencer states
  typedef enum logic [2:0] {
    SSP_IDLE = 3'b001,
    SSP_LEAD = 3'b010,
    SSP_TRAIL = 3'b100
  } ssp_state_e;
endpackage

// ==== logic/ssp_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } ssp_sync_s;

  ssp_sync_s s_q;
  ssp_sync_s s_d;

  if (WIDTH < 1) begin : g_chk
    $error("ssp_sync: WIDTH must be at least 1");
  end

  always_comb begin
    s_d.meta = async_i;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.sync;
endmodule
`default_nettype wire

// ==== logic/ssp_fifo.sv ====
// transmit byte queue with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic wr_valid_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic wr_ready_o,
  output logic rd_valid_o,
  output logic [WIDTH-1:0] rd_data_o,
  input wire logic rd_ready_i
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
    logic vld;
  } ssp_fifo_s;

  ssp_fifo_s s_q;
  ssp_fifo_s s_d;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("ssp_fifo: DEPTH must be a power of two >= 2");
  end

  always_comb begin
    s_d = s_q;
    push = wr_valid_i && s_q.rdy;
    pop = rd_ready_i && s_q.vld;
    if (push) begin
      s_d.mem[s_q.wp] = wr_data_i;
      s_d.wp = AW'(s_q.wp + 1'b1);
    end
    if (pop) begin
      s_d.rp = AW'(s_q.rp + 1'b1);
    end
    if (push && !pop) begin
      s_d.cnt = (AW + 1)'(s_q.cnt + 1'b1);
    end else if (pop && !push) begin
      s_d.cnt = (AW + 1)'(s_q.cnt - 1'b1);
    end
    s_d.rdy = (s_d.cnt != CNT_FULL);
    s_d.vld = (s_d.cnt != '0);
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wr_ready_o = s_q.rdy;
  assign rd_valid_o = s_q.vld;
  assign rd_data_o = s_q.mem[s_q.rp];
endmodule
`default_nettype wire

// ==== logic/ssp_spi_port.sv ====
// synchronous serial port, spi master and slave
//
// Contract
// [RULE1] port works only while enable bit 5 is set; then it owns its pins
// [RULE2] software reconfigures by clearing enable, rewriting control, setting enable again
// [RULE3] software sets directions: input 4 in, output 5 out, clock 3, select in
// [RULE4] a pin whose direction opposes the serial need becomes general purpose
// [RULE5] master starts every transfer by driving the clock; slave waits for it
// [RULE6] data shifts out on one clock edge and is sampled on the other
// [RULE7] same polarity both ends; every transfer is full duplex, real or dummy
// [RULE8] in master mode a buffer write starts shifting that byte at once; code queues it and starts it only from idle with sleep_i low
// [RULE9] master with clock pin as input keeps sampling at the bit rate
// [RULE10] monitored bytes load the buffer and set flags like normal bytes
// [RULE11] slave shifts only on edges of the external clock
// [RULE12] sampling the last bit sets the done flag, bit 3 of flag register
// [RULE13] shift clock idles at the level of polarity bit 4
// [RULE14] bytes move most significant bit first both ways
// [RULE15] master bit clock is core clock over 4, 16, 64, or timer over 2
// [RULE16] in sleep the slave keeps working and wakes the device on completion
// [RULE17] shifter is eight bits; after eight samples the byte loads the buffer
// [RULE18] control register mode field selects master rate or slave operation
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_port #(
  parameter int unsigned FIFO_DEPTH = ssp_pkg::TX_FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] port_control_reg_i,
  input wire logic [7:0] portc_direction_reg_i,
  input wire logic [7:0] porta_direction_reg_i,
  input wire logic timer_tick_i,
  input wire logic sleep_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  input wire logic rx_read_i,
  input wire logic flag_clear_i,
  input wire logic overflow_clear_i,
  output logic [7:0] rx_data_o,
  output logic buffer_full_o,
  output logic overflow_o,
  output logic [7:0] peripheral_flag_reg_o,
  output logic wake_o,
  input wire logic [3:0] pin_in_i,
  input wire logic [3:0] gp_out_i,
  output logic [3:0] pin_out_o,
  output logic [3:0] pin_oe_n_o
);
  typedef struct packed {
    ssp_pkg::ssp_state_e st;
    logic [7:0] sh;
    logic samp;
    logic [3:0] cnt;
    logic sck;
    logic [4:0] div;
    logic loaded;
    logic sck_prev;
    logic [7:0] rxbuf;
    logic full;
    logic ovf;
    logic [7:0] pflag;
    logic wake;
    logic [3:0] pout;
    logic [3:0] poe_n;
  } ssp_core_s;

  ssp_core_s s_q;
  ssp_core_s s_d;

  logic [3:0] pin_s;
  logic [3:0] dir;
  logic [3:0] want_dir;
  logic [3:0] owned;
  logic en;
  logic cpol;
  logic [3:0] mode;
  logic is_master;
  logic is_slave;
  logic selected;
  logic sck_s;
  logic sdi_s;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic pop;
  logic tick;
  logic lead;
  logic trail;
  logic done_evt;
  logic [7:0] byte_in;
  logic [4:0] half_top;

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("ssp_spi_port: FIFO_DEPTH must be at least 2");
  end

  ssp_sync #(
    .WIDTH(ssp_pkg::PIN_COUNT)
  ) u_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(pin_in_i),
    .sync_o(pin_s)
  );

  ssp_fifo #(
    .WIDTH(ssp_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_txq (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .wr_valid_i(tx_valid_i),
    .wr_data_i(tx_data_i),
    .wr_ready_o(tx_ready_o),
    .rd_valid_o(fifo_valid),
    .rd_data_o(fifo_data),
    .rd_ready_i(pop)
  );

  assign en = port_control_reg_i[ssp_pkg::CTRL_ENABLE_BIT];
  assign cpol = port_control_reg_i[ssp_pkg::CTRL_POLARITY_BIT];
  assign mode = port_control_reg_i[ssp_pkg::CTRL_MODE_LSB +: ssp_pkg::CTRL_MODE_W];
  // mode field picks master rate or slave flavour
  assign is_master = en && (mode <= ssp_pkg::MODE_M_TIMER); // RULE18
  assign is_slave = en && (mode == ssp_pkg::MODE_S_SELECT || mode == ssp_pkg::MODE_S_NOSELECT);
  assign sck_s = pin_s[ssp_pkg::PIN_SCK];
  assign sdi_s = pin_s[ssp_pkg::PIN_SDI];

  assign dir[ssp_pkg::PIN_SCK] = portc_direction_reg_i[ssp_pkg::DIR_SCK_BIT];
  assign dir[ssp_pkg::PIN_SDI] = portc_direction_reg_i[ssp_pkg::DIR_SDI_BIT];
  assign dir[ssp_pkg::PIN_SDO] = portc_direction_reg_i[ssp_pkg::DIR_SDO_BIT];
  assign dir[ssp_pkg::PIN_SS] = porta_direction_reg_i[ssp_pkg::DIR_SS_BIT];
  // direction each pin needs to serve the port
  assign want_dir[ssp_pkg::PIN_SCK] = !is_master; // RULE3
  assign want_dir[ssp_pkg::PIN_SDI] = 1'b1;
  assign want_dir[ssp_pkg::PIN_SDO] = 1'b0;
  assign want_dir[ssp_pkg::PIN_SS] = 1'b1;
  // enable hands pins over; an opposed direction keeps a pin general purpose
  assign owned = {4{en}} & ~(dir ^ want_dir); // RULE1 RULE4

  // select pin used as output means the slave ignores select
  assign selected = (mode == ssp_pkg::MODE_S_NOSELECT) || !owned[ssp_pkg::PIN_SS] ||
                    !pin_s[ssp_pkg::PIN_SS];

  always_comb begin
    case (mode)
      ssp_pkg::MODE_M_DIV16: half_top = ssp_pkg::HALF_TOP_DIV16;
      ssp_pkg::MODE_M_DIV64: half_top = ssp_pkg::HALF_TOP_DIV64;
      default: half_top = ssp_pkg::HALF_TOP_DIV4;
    endcase
  end

  always_comb begin
    s_d = s_q;
    pop = 1'b0;
    tick = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    done_evt = 1'b0;
    byte_in = '0;
    s_d.wake = 1'b0;
    s_d.sck_prev = sck_s;
    // half-period tick of the master bit clock
    if (mode == ssp_pkg::MODE_M_TIMER) begin
      tick = timer_tick_i; // RULE15
    end else begin
      tick = (s_q.div == half_top); // RULE15
    end
    if (s_q.st == ssp_pkg::SSP_IDLE || tick) begin
      s_d.div = '0;
    end else begin
      s_d.div = 5'(s_q.div + 1'b1);
    end
    if (!en) begin
      s_d.st = ssp_pkg::SSP_IDLE; // RULE1
      s_d.cnt = '0;
      s_d.loaded = 1'b0;
      s_d.sck = cpol;
    end else if (is_master) begin
      // clock runs from the sequencer even if the pin is an input
      case (s_q.st)
        ssp_pkg::SSP_IDLE: begin
          s_d.sck = cpol; // RULE13
          if (fifo_valid && !sleep_i) begin
            pop = 1'b1; // RULE8 RULE5
            s_d.sh = fifo_data;
            s_d.cnt = '0;
            s_d.st = ssp_pkg::SSP_LEAD;
          end
        end
        ssp_pkg::SSP_LEAD: begin
          if (tick) begin
            s_d.sck = !cpol;
            lead = 1'b1; // RULE9
            s_d.st = ssp_pkg::SSP_TRAIL;
          end
        end
        ssp_pkg::SSP_TRAIL: begin
          if (tick) begin
            s_d.sck = cpol; // RULE13
            trail = 1'b1;
            s_d.st = (s_q.cnt == ssp_pkg::BYTE_BITS) ? ssp_pkg::SSP_IDLE : ssp_pkg::SSP_LEAD;
          end
        end
        default: begin
          s_d.st = ssp_pkg::SSP_IDLE;
        end
      endcase
    end else if (is_slave) begin
      s_d.st = ssp_pkg::SSP_IDLE;
      s_d.sck = cpol;
      // edges of the synchronised external clock only
      lead = selected && (sck_s != s_q.sck_prev) && (sck_s != cpol); // RULE11 RULE5
      trail = selected && (sck_s != s_q.sck_prev) && (sck_s == cpol); // RULE11
      if (!selected) begin
        s_d.cnt = '0;
      end
      if (s_q.cnt == '0 && !s_q.loaded && fifo_valid) begin
        pop = 1'b1;
        s_d.sh = fifo_data;
        s_d.loaded = 1'b1;
      end
    end else begin
      s_d.st = ssp_pkg::SSP_IDLE;
      s_d.cnt = '0;
      s_d.sck = cpol;
    end
    // slave samples on the leading edge; both shift out on the trailing edge
    if (lead) begin
      s_d.samp = sdi_s; // RULE6
      s_d.cnt = 4'(s_q.cnt + 1'b1);
      if (is_slave && s_q.cnt == ssp_pkg::LAST_BIT) begin
        done_evt = 1'b1; // RULE17
        byte_in = {s_q.sh[6:0], sdi_s}; // RULE14 RULE7
      end
    end
    if (trail) begin
      // master input is seen two cycles late: at its trailing tick the
      // synchroniser still shows the bit of the leading edge; needs ticks >= 2 apart
      s_d.sh = {s_q.sh[6:0], is_master ? sdi_s : s_q.samp}; // RULE6 RULE14 RULE7
      if (is_master && s_q.cnt == ssp_pkg::BYTE_BITS) begin
        done_evt = 1'b1; // RULE17
        byte_in = {s_q.sh[6:0], sdi_s}; // RULE14 RULE7
      end
      if (is_slave && s_q.cnt == ssp_pkg::BYTE_BITS) begin
        s_d.cnt = '0;
        s_d.loaded = 1'b0;
      end
    end
    // clears first so that a completing byte wins
    if (rx_read_i) begin
      s_d.full = 1'b0;
    end
    if (flag_clear_i) begin
      s_d.pflag[ssp_pkg::FLAG_DONE_BIT] = 1'b0;
    end
    if (overflow_clear_i) begin
      s_d.ovf = 1'b0;
    end
    if (done_evt) begin
      s_d.pflag[ssp_pkg::FLAG_DONE_BIT] = 1'b1; // RULE12 RULE10
      s_d.wake = sleep_i; // RULE16
      if (s_q.full && !rx_read_i) begin
        s_d.ovf = 1'b1;
      end else begin
        s_d.rxbuf = byte_in; // RULE10 RULE17
        s_d.full = 1'b1;
      end
    end
    // pin drivers, low enable drives the pin
    for (int i = 0; i < 4; i++) begin
      if (owned[i]) begin
        // an owned pin is driven only where the port needs an output
        s_d.poe_n[i] = want_dir[i]; // RULE1 RULE3
        if (i == ssp_pkg::PIN_SDO) begin
          s_d.pout[i] = s_d.sh[7]; // RULE14
        end else if (i == ssp_pkg::PIN_SCK) begin
          s_d.pout[i] = s_d.sck; // RULE13
        end else begin
          s_d.pout[i] = 1'b0;
        end
      end else begin
        s_d.poe_n[i] = dir[i]; // RULE4 RULE9
        s_d.pout[i] = gp_out_i[i]; // RULE4
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
      s_q.st <= ssp_pkg::SSP_IDLE;
      s_q.poe_n <= 4'hf;
    end else begin
      s_q <= s_d;
    end
  end

  assign rx_data_o = s_q.rxbuf;
  assign buffer_full_o = s_q.full;
  assign overflow_o = s_q.ovf;
  assign peripheral_flag_reg_o = s_q.pflag;
  assign wake_o = s_q.wake;
  assign pin_out_o = s_q.pout;
  assign pin_oe_n_o = s_q.poe_n;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  sequence seq_lead_two;
    (s_q.st == ssp_pkg::SSP_LEAD) [*2];
  endsequence

  sequence seq_then_trail;
    s_q.st == ssp_pkg::SSP_TRAIL;
  endsequence

  a_done_flag_set: assert property ( // RULE12
    done_evt |=> s_q.pflag[ssp_pkg::FLAG_DONE_BIT])
    else $error("done flag not set after last bit");

  a_flag_set_wins: assert property ( // RULE10
    (done_evt && flag_clear_i && !s_q.full) |=> (s_q.pflag[3] && s_q.full &&
      s_q.rxbuf == $past(byte_in)))
    else $error("completed byte lost against a clear");

  a_disable_idle: assert property ( // RULE1
    !en |=> (s_q.st == ssp_pkg::SSP_IDLE && s_q.cnt == 4'h0 && s_q.poe_n[2] == $past(dir[2])))
    else $error("port active while disabled");

  a_master_start: assert property ( // RULE8
    (is_master && !sleep_i && fifo_valid && s_q.st == ssp_pkg::SSP_IDLE) |=>
      (s_q.st == ssp_pkg::SSP_LEAD && s_q.sh == $past(fifo_data) && s_q.cnt == 4'h0))
    else $error("buffer write did not start a transfer");

  a_div4_rate: assert property ( // RULE15
    disable iff (!resetn_i || !en)
    ($rose(s_q.st == ssp_pkg::SSP_LEAD) && mode == ssp_pkg::MODE_M_DIV4 && $stable(mode))
      |-> seq_lead_two ##1 seq_then_trail)
    else $error("wrong half period at core clock over four");

  a_idle_polarity: assert property ( // RULE13
    (s_q.st == ssp_pkg::SSP_IDLE && $stable(cpol) && $past(s_q.st) == ssp_pkg::SSP_IDLE)
      |-> (s_q.sck == cpol))
    else $error("shift clock not at idle level");

  a_byte_end: assert property ( // RULE17
    (s_q.st == ssp_pkg::SSP_TRAIL && tick && is_master && s_q.cnt == 4'h8)
      |=> (s_q.st == ssp_pkg::SSP_IDLE && s_q.sck == $past(cpol)))
    else $error("master did not stop after eight bits");

  a_slave_sample: assert property ( // RULE11
    (is_slave && lead) |=> (s_q.samp == $past(sdi_s) && s_q.cnt == 4'($past(s_q.cnt) + 1)))
    else $error("slave missed a leading edge sample");

  a_slave_quiet: assert property ( // RULE5
    (is_slave && $stable(sck_s) && $past(sck_s) == s_q.sck_prev && !pop) |=> $stable(s_q.sh))
    else $error("slave shifted without a clock edge");

  a_sleep_wake: assert property ( // RULE16
    (done_evt && sleep_i) |=> wake_o ##1 !wake_o)
    else $error("no wake pulse on completion in sleep");

  a_recv_only: assert property ( // RULE9
    (is_master && dir[0]) |=> (pin_oe_n_o[0] && pin_out_o[0] == $past(gp_out_i[0])))
    else $error("clock pin driven in receive only use");

  a_gpio_yield: assert property ( // RULE4
    (!dir[1]) |=> (!pin_oe_n_o[1] && pin_out_o[1] == $past(gp_out_i[1])))
    else $error("input pin did not yield to general use");
endmodule
`default_nettype wire

// ==== tb/ssp_peer.sv ====
// far-side spi device model, acting as slave or as master
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
  input wire logic clock_i,
  input wire logic master_i,
  input wire logic pol_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic sck_o,
  output logic ss_n_o,
  output logic [7:0] rx_o
);
  logic [7:0] tx_q;
  initial begin
    miso_o = 1'b0;
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    rx_o = 8'h00;
    tx_q = 8'h00;
  end
  task automatic load(input logic [7:0] b);
    tx_q = b;
    miso_o = b[7];
  endtask
  task automatic edge_lead();
    rx_o = {rx_o[6:0], mosi_i};
  endtask
  // spent bits refill with a changing pattern
  task automatic edge_trail();
    tx_q = {tx_q[6:0], ~tx_q[0]};
    miso_o = tx_q[7];
  endtask
  always @(sck_i) begin
    if (!master_i && sck_i === !pol_i) begin
      edge_lead();
    end else if (!master_i && sck_i === pol_i) begin
      edge_trail();
    end
  end
  task automatic xfer(input logic [7:0] b, input int half, input logic sel);
    ss_n_o = !sel;
    load(b);
    sck_o = pol_i;
    repeat (half) @(posedge clock_i);
    repeat (8) begin
      #1;
      sck_o = !pol_i;
      edge_lead();
      repeat (half) @(posedge clock_i);
      #1;
      sck_o = pol_i;
      edge_trail();
      repeat (half) @(posedge clock_i);
    end
    ss_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== tb/ssp_spi_port_tb.sv ====
// self-checking bench of the spi port against the far-side model
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_port_tb;
  logic clock_i, resetn_i, timer_tick_i, sleep_i, tx_valid_i, rx_read_i;
  logic flag_clear_i, overflow_clear_i, tx_ready_o, buffer_full_o, overflow_o, wake_o;
  logic [7:0] ctrl, dir_c, dir_a, tx_data_i, rx_data_o, flag_o, peer_rx;
  logic [3:0] gp_out_i, pin_out_o, pin_oe_n_o, ext, pin_w;
  logic peer_m, peer_miso, peer_sck, peer_ss_n, woke;
  int miscompares, cmp_count, cycles, tcnt;

  ssp_spi_port i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .port_control_reg_i(ctrl),
    .portc_direction_reg_i(dir_c), .porta_direction_reg_i(dir_a),
    .timer_tick_i(timer_tick_i), .sleep_i(sleep_i), .tx_valid_i(tx_valid_i),
    .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .rx_read_i(rx_read_i),
    .flag_clear_i(flag_clear_i), .overflow_clear_i(overflow_clear_i),
    .rx_data_o(rx_data_o), .buffer_full_o(buffer_full_o), .overflow_o(overflow_o),
    .peripheral_flag_reg_o(flag_o), .wake_o(wake_o), .pin_in_i(pin_w),
    .gp_out_i(gp_out_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o));
  ssp_peer i_peer (.clock_i(clock_i), .master_i(peer_m), .pol_i(ctrl[4]),
    .sck_i(pin_w[0]), .mosi_i(pin_w[2]), .miso_o(peer_miso), .sck_o(peer_sck),
    .ss_n_o(peer_ss_n), .rx_o(peer_rx));

  // undriven serial out shows the inverse of its last level
  assign ext = {peer_ss_n, ~pin_out_o[2], peer_miso, peer_m ? peer_sck : ctrl[4]};
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_w[i] = (pin_oe_n_o[i] === 1'b0) ? pin_out_o[i] : ext[i];
    end
  end

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    #1;
    tcnt = (tcnt == 4) ? 0 : tcnt + 1;
    timer_tick_i = (tcnt == 0);
    cycles++;
    if (wake_o === 1'b1) begin
      woke = 1'b1;
    end
    if (cycles == 40000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk8(input logic [7:0] exp, input logic [7:0] act);
    cmp_count++;
    if (act !== exp) begin
      miscompares++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, act);
    end
  endtask
  task automatic chki(input int exp, input int act);
    cmp_count++;
    if (act != exp) begin
      miscompares++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, act);
    end
  endtask
  task automatic cfg(input logic [7:0] c, input logic [7:0] d);
    ctrl[5] = 1'b0;
    step(1);
    ctrl = c & 8'hdf;
    dir_c = d;
    step(1);
    ctrl = c;
    step(3);
  endtask
  task automatic wr(input logic [7:0] b);
    tx_valid_i = 1'b1;
    tx_data_i = b;
    step(1);
    tx_valid_i = 1'b0;
  endtask
  task automatic until_sck(input logic v, output int n);
    n = 0;
    while (pin_w[0] !== v && n < 500) begin
      step(1);
      n++;
    end
  endtask
  task automatic wait_done(input logic [7:0] exp_rx, input logic [7:0] exp_peer);
    int k;
    k = 0;
    while (flag_o[3] !== 1'b1 && k < 3000) begin
      step(1);
      k++;
    end
    chk8(8'h08, flag_o);
    chk8(exp_rx, rx_data_o);
    chk8(8'h01, {7'h00, buffer_full_o});
    chk8(exp_peer, peer_rx);
    flag_clear_i = 1'b1;
    rx_read_i = 1'b1;
    step(1);
    flag_clear_i = 1'b0;
    rx_read_i = 1'b0;
    step(1);
  endtask

  task automatic s_pins();
    gp_out_i = 4'h6;
    cfg(8'h00, 8'hd7);
    chk8(8'h0a, {4'h0, pin_oe_n_o});
    chk8(8'h06, {4'h0, pin_out_o});
    i_peer.load(8'h81);
    wr(8'h5a);
    step(100);
    chk8(8'h00, flag_o);
    cfg(8'h20, 8'hc7);
    chk8(8'h01, {6'h00, pin_oe_n_o[1], pin_out_o[1]});
    wait_done(8'hff, 8'h5a);
    // receive only: clock pin as input, peer never clocked
    cfg(8'h20, 8'hdf);
    i_peer.load(8'h00);
    wr(8'h3c);
    wait_done(8'h00, 8'h5a);
    chk8(8'h01, {7'h00, pin_oe_n_o[0]});
  endtask
  task automatic s_xfer();
    for (int p = 0; p < 2; p++) begin
      cfg({3'b001, p[0], 4'h0}, 8'hd7);
      chk8({7'h00, p[0]}, {7'h00, pin_w[0]});
      i_peer.load(8'h3c ^ {8{p[0]}});
      wr(8'ha5);
      wait_done(8'h3c ^ {8{p[0]}}, 8'ha5);
    end
  endtask
  task automatic s_rates();
    int half [4] = '{2, 8, 32, 5};
    int n0, n1, n2;
    for (int m = 0; m < 4; m++) begin
      cfg({4'h2, m[3:0]}, 8'hd7);
      i_peer.load(8'hc3);
      wr(8'h18);
      until_sck(1'b1, n0);
      until_sck(1'b0, n1);
      until_sck(1'b1, n2);
      chki(2 * half[m], n1 + n2);
      wait_done(8'hc3, 8'h18);
    end
  endtask
  task automatic s_queue();
    gp_out_i = 4'h0;
    cfg(8'h20, 8'hc7);
    sleep_i = 1'b1;
    tx_valid_i = 1'b1;
    for (int i = 0; i < 9; i++) begin
      tx_data_i = 8'h10 + 8'(i);
      step(1);
    end
    tx_valid_i = 1'b0;
    chk8(8'h00, {7'h00, tx_ready_o});
    sleep_i = 1'b0;
    for (int i = 0; i < 8; i++) begin
      wait_done(8'h00, 8'h10 + 8'(i));
    end
    step(100);
    chk8(8'h00, flag_o);
  endtask
  task automatic s_overrun();
    cfg(8'h20, 8'hc7);
    tx_valid_i = 1'b1;
    tx_data_i = 8'h11;
    step(2);
    tx_valid_i = 1'b0;
    step(120);
    chk8(8'h01, {7'h00, overflow_o});
    overflow_clear_i = 1'b1;
    step(1);
    overflow_clear_i = 1'b0;
    chk8(8'h00, {7'h00, overflow_o});
    wait_done(8'h00, 8'h11);
  endtask
  task automatic s_slave();
    for (int m = 4; m < 6; m++) begin
      cfg({4'h2, m[3:0]}, 8'hdf);
      wr(8'h5a ^ 8'(m));
      peer_m = 1'b1;
      sleep_i = 1'b1;
      woke = 1'b0;
      i_peer.xfer(8'h96, 6, m == 4);
      wait_done(8'h96, 8'h5a ^ 8'(m));
      chk8(8'h01, {7'h00, woke});
      sleep_i = 1'b0;
      peer_m = 1'b0;
    end
  endtask

  initial begin
    resetn_i = 1'b0;
    ctrl = 8'h00;
    dir_c = 8'hff;
    dir_a = 8'hff;
    timer_tick_i = 1'b0;
    sleep_i = 1'b0;
    tx_valid_i = 1'b0;
    tx_data_i = 8'h00;
    rx_read_i = 1'b0;
    flag_clear_i = 1'b0;
    overflow_clear_i = 1'b0;
    gp_out_i = 4'h0;
    peer_m = 1'b0;
    woke = 1'b0;
    step(20);
    resetn_i = 1'b1;
    step(2);
    s_pins();
    s_xfer();
    s_rates();
    s_queue();
    s_overrun();
    s_slave();
    conclude();
  end
endmodule
`default_nettype wire
